// *** rtl/gain_select_cfg.svh ***
// Purpose: Named constants for the cutting/rapid gain selector.
// Assumes: A 20 MHz system clock and a register word of 16 bits in a 32-bit bus.
// Notes:   Register offsets are word indices; the byte address is four times the index.
`ifndef GAIN_SELECT_CFG_SVH
`define GAIN_SELECT_CFG_SVH

`define CLK_PERIOD_NS     50
`define SERVO_PERIOD_NS   1000000
`define SERVO_CYCLES      (`SERVO_PERIOD_NS / `CLK_PERIOD_NS)

`define REG_COUNT         15
`define IDX_FEED_SW       4'h0
`define IDX_DIAG          4'h1
`define IDX_VEL_BASE      4'h2
`define IDX_CUT_OVR       4'h3
`define IDX_FAST_OVR      4'h4
`define IDX_FAST_MAG      4'h5
`define IDX_TC_BASE       4'h6
`define IDX_TC_CUT        4'h7
`define IDX_PFF_BASE      4'h8
`define IDX_PFF_CUT       4'h9
`define IDX_VFF_BASE      4'ha
`define IDX_VFF_CUT       4'hb
`define IDX_MODE_CFG      4'hc
`define IDX_RES_COEF      4'hd
`define IDX_MAX_CUR       4'he

`define BIT_ACCEL_SW      0
`define BIT_GAIN_SW       1
`define BIT_ACTIVE        0
`define BIT_READY         1
`define BIT_BYPASS        0
`define BIT_TQ_FILT       1
`define BIT_RES_FILT      2

`define RST_ZERO          16'h0000
`define RST_PCT_UNITY     16'h0064
`define RST_MAX_CUR       16'hffff

`define PCT_UNITY         16'h0064
`define CUT_OVR_MIN       16'h0032
`define CUT_OVR_MAX       16'h0190
`define FAST_OVR_MIN      16'h0064
`define FAST_OVR_MAX      16'h0190
`define FAST_MAG_MIN      16'h0064
`define FAST_MAG_MAX      16'h010e
`define GAIN_DEN          17'h00100
`define GAIN_SHIFT        8
`define TORQUE_LIMIT_PCT  16'h0046

`endif

// *** rtl/gain_select_pkg.sv ***
// Purpose: Shared types of the cutting/rapid gain selector.
// Assumes: Nothing beyond the constants header.
// Notes:   Numbers live in gain_select_cfg.svh.
package gain_select_pkg;

	typedef enum logic {
		CODE_OFF,
		CODE_ON
	} code_state_t;

	typedef logic [15:0] word_t;

endpackage : gain_select_pkg

// *** rtl/servo_param_math.sv ***
// Purpose: Velocity gain arithmetic and torque command clamp.
// Assumes: tick_i is a one-cycle pulse per servo cycle.
// Notes:   Gain and limit move only on tick_i; the torque path is registered every clock and clamped while clamp_i is set.
`timescale 1ns/100ps
`include "gain_select_cfg.svh"

module servo_param_math
	import gain_select_pkg::*;
(
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Servo cycle and operands.
	input  wire logic               tick_i,
	input  wire word_t              vel_base_i,
	input  wire word_t              vel_mult_i,
	input  wire word_t              max_current_i,
	input  wire logic               clamp_i,
	input  wire logic signed [15:0] torque_command_i,
	// Results.
	output logic        [24:0]      vel_gain_o,
	output logic signed [15:0]      torque_command_o
);

	logic        [24:0] gain_d;
	logic        [15:0] limit_q;
	logic        [15:0] limit_d;
	logic signed [15:0] torque_d;
	logic        [32:0] product;
	logic        [31:0] limit_prod;
	logic signed [16:0] tq_ext;
	logic signed [16:0] lim_ext;

	always_comb begin
		product    = ({16'h0000, `GAIN_DEN} + 33'(vel_base_i)) * 33'(vel_mult_i);
		limit_prod = 32'(max_current_i) * 32'(`TORQUE_LIMIT_PCT);
		gain_d     = vel_gain_o;
		limit_d    = limit_q;
		if (tick_i) begin
			gain_d  = product[24 + `GAIN_SHIFT:`GAIN_SHIFT];
			limit_d = 16'(limit_prod / 32'(`PCT_UNITY));
		end
		tq_ext  = 17'(torque_command_i);
		lim_ext = signed'({1'b0, limit_q});
		torque_d = torque_command_i;
		// A limit above the signed range can never be exceeded, so truncation here is safe.
		if (clamp_i && tq_ext > lim_ext) begin
			torque_d = signed'(limit_q);
		end else if (clamp_i && tq_ext < -lim_ext) begin
			torque_d = 16'(-lim_ext);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vel_gain_o       <= '0;
			limit_q          <= '0;
			torque_command_o <= '0;
		end else begin
			vel_gain_o       <= gain_d;
			limit_q          <= limit_d;
			torque_command_o <= torque_d;
		end
	end

	property p_gain_formula;
		@(posedge clk_i) disable iff (rst_i)
		tick_i |=> vel_gain_o == 25'((($past(33'(vel_base_i)) + 33'(`GAIN_DEN)) * $past(33'(vel_mult_i)))
			>> `GAIN_SHIFT);
	endproperty
	a_gain_formula: assert property (p_gain_formula) else $error("velocity gain formula wrong");

	property p_torque_clamped;
		@(posedge clk_i) disable iff (rst_i)
		(clamp_i && tq_ext > lim_ext) |=> torque_command_o == signed'($past(limit_q));
	endproperty
	a_torque_clamped: assert property (p_torque_clamped) else $error("torque not clamped");

	property p_torque_pass;
		@(posedge clk_i) disable iff (rst_i)
		!clamp_i |=> torque_command_o == $past(torque_command_i);
	endproperty
	a_torque_pass: assert property (p_torque_pass) else $error("torque altered without clamp");

	c_clamp_hit: cover property (@(posedge clk_i) disable iff (rst_i) clamp_i && tq_ext > lim_ext);

endmodule : servo_param_math

// *** rtl/cutting_rapid_gain_select.sv ***
// Purpose: Per-axis cutting/rapid parameter selection and fast current-loop mode tracking.
// Assumes: Classic Wishbone slave, 20 MHz clock, interpreter strobes on the same clock.
// Notes:   All loop-facing outputs except torque_command_o move only on the servo cycle tick; the torque command is registered every clock.
// Overview of operation
// - Fast mode counts only for cutting commands between the enter code and the leave code, or for any cutting command with code bypass set.
// - After reset the ready flag (diagnostic bit 1) is set when the fast option is configured and usable.
// - With ready set and the enter code in effect, the active flag (bit 0) is 1 during cutting feed.
// - With ready and code bypass set, the active flag is 1 during every cutting feed without the enter code.
// - While active, the current loop runs its fast cycle with the fast current gain magnification.
// - Bit 1 of the switch control register enables cutting/rapid velocity gain switching.
// - Velocity gain is (1 + base/256) times 100, or times the cutting override in switched cutting feed.
// - The cutting override accepts only 50 to 400 percent, and software must write within that range.
// - While fast mode is active a separate fast override replaces the cutting override.
// - Bit 0 of the switch control register enables cutting/rapid acceleration switching.
// - With acceleration switching on, cutting uses the alternate time constant and feed-forward set.
// - The resonance filter settings are never switched between cutting and rapid.
// - The torque filter and the resonance filter may both be enabled together.
// - During cutting in fast mode the torque command is clamped to 70 percent of maximum current.
`timescale 1ns/100ps
`include "gain_select_cfg.svh"

module cutting_rapid_gain_select
	import gain_select_pkg::*;
#(
	parameter int SERVO_CYCLES = `SERVO_CYCLES
) (
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave.
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [7:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	// Option straps from pins.
	input  wire logic               fast_option_i,
	input  wire logic               fast_capable_i,
	// Program interpreter.
	input  wire logic               cutting_i,
	input  wire logic               mode_enter_code_i,
	input  wire logic               mode_leave_code_i,
	// Torque path.
	input  wire logic signed [15:0] torque_command_i,
	output logic signed [15:0]      torque_command_o,
	// Loop parameters.
	output logic      [24:0]        vel_gain_o,
	output word_t                   current_gain_o,
	output logic                    fast_cycle_o,
	output word_t                   fine_accel_decel_o,
	output word_t                   pos_feed_forward_o,
	output word_t                   vel_feed_forward_o,
	output word_t                   resonance_coef_o,
	output logic                    torque_filter_en_o,
	output logic                    resonance_filter_en_o,
	output logic                    fast_mode_ready_o,
	output logic                    fast_mode_active_o
);

	function automatic word_t merge16(input word_t old, input logic [31:0] dat, input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = dat[15:8];
		end
	endfunction : merge16

	function automatic word_t reset_value(input int idx);
		if (idx == int'(`IDX_CUT_OVR) || idx == int'(`IDX_FAST_OVR) || idx == int'(`IDX_FAST_MAG)) begin
			reset_value = `RST_PCT_UNITY;
		end else if (idx == int'(`IDX_MAX_CUR)) begin
			reset_value = `RST_MAX_CUR;
		end else begin
			reset_value = `RST_ZERO;
		end
	endfunction : reset_value

	// Out-of-range values are dropped whole, so the loop never sees a half-valid override.
	function automatic logic write_ok(input int idx, input word_t v);
		if (idx == int'(`IDX_DIAG)) begin
			write_ok = 1'b0;
		end else if (idx == int'(`IDX_CUT_OVR)) begin
			write_ok = v >= `CUT_OVR_MIN && v <= `CUT_OVR_MAX;
		end else if (idx == int'(`IDX_FAST_OVR)) begin
			write_ok = v >= `FAST_OVR_MIN && v <= `FAST_OVR_MAX;
		end else if (idx == int'(`IDX_FAST_MAG)) begin
			write_ok = v >= `FAST_MAG_MIN && v <= `FAST_MAG_MAX;
		end else begin
			write_ok = 1'b1;
		end
	endfunction : write_ok

	// Bus slave and register file.
	word_t       regs_q [`REG_COUNT];
	word_t       regs_d [`REG_COUNT];
	logic        ack_q;
	logic        ack_d;
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	logic [3:0]  idx;
	logic        mapped;
	logic        wr_en;
	word_t       wr_val;

	assign idx = adr_i[5:2];

	always_comb begin
		mapped = adr_i[7:6] == 2'b00 && int'(idx) < `REG_COUNT && adr_i[1:0] == 2'b00;
		ack_d  = cyc_i && stb_i && !ack_q;
		// A write lands at the edge where the master samples ack, while its request still stands.
		wr_en  = ack_q && cyc_i && stb_i && we_i && mapped;
		dat_d  = dat_q;
		wr_val = merge16(regs_q[idx], dat_i, sel_i);
		if (ack_d && !we_i) begin
			if (!mapped) begin
				dat_d = '0;
			end else if (idx == `IDX_DIAG) begin
				dat_d = 32'({fast_mode_ready_o, fast_mode_active_o});
			end else begin
				dat_d = 32'(regs_q[idx]);
			end
		end
	end

	generate
		for (genvar i = 0; i < `REG_COUNT; i++) begin : g_reg
			always_comb begin
				regs_d[i] = regs_q[i];
				if (wr_en && int'(idx) == i && write_ok(i, wr_val)) begin
					regs_d[i] = wr_val;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					regs_q[i] <= reset_value(i);
				end else begin
					regs_q[i] <= regs_d[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// Servo cycle divider.
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic        tick;

	always_comb begin
		tick  = div_q == 16'(SERVO_CYCLES - 1);
		div_d = tick ? '0 : div_q + 16'h0001;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// Strap synchronisers and ready capture.
	logic [1:0] opt_sync_q;
	logic [1:0] cap_sync_q;
	logic       ready_d;
	logic       ready_taken_q;
	logic       ready_taken_d;

	always_comb begin
		ready_d       = fast_mode_ready_o;
		ready_taken_d = ready_taken_q;
		// Caught once per reset, so a strap change only counts after the next reset.
		if (tick && !ready_taken_q) begin
			ready_d       = opt_sync_q[1] && cap_sync_q[1];
			ready_taken_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opt_sync_q        <= '0;
			cap_sync_q        <= '0;
			fast_mode_ready_o <= 1'b0;
			ready_taken_q     <= 1'b0;
		end else begin
			opt_sync_q        <= {opt_sync_q[0], fast_option_i};
			cap_sync_q        <= {cap_sync_q[0], fast_capable_i};
			fast_mode_ready_o <= ready_d;
			ready_taken_q     <= ready_taken_d;
		end
	end

	// Program-code mode tracking; codes are held between ticks so none is lost.
	code_state_t code_q;
	code_state_t code_d;

	always_comb begin
		code_d = code_q;
		case (code_q)
			CODE_OFF: begin
				if (mode_enter_code_i && !mode_leave_code_i) begin
					code_d = CODE_ON;
				end
			end
			CODE_ON: begin
				if (mode_leave_code_i) begin
					code_d = CODE_OFF;
				end
			end
			default: begin
				code_d = CODE_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_q <= CODE_OFF;
		end else begin
			code_q <= code_d;
		end
	end

	// Per-cycle parameter selection.
	logic  gain_sw;
	logic  accel_sw;
	logic  bypass;
	logic  active_d;
	logic  cut_alt;
	word_t vel_mult;
	word_t cur_gain_d;
	word_t tc_d;
	word_t pff_d;
	word_t vff_d;
	word_t res_d;
	logic  tqf_d;
	logic  resf_d;

	always_comb begin
		gain_sw  = regs_q[`IDX_FEED_SW][`BIT_GAIN_SW];
		accel_sw = regs_q[`IDX_FEED_SW][`BIT_ACCEL_SW];
		bypass   = regs_q[`IDX_MODE_CFG][`BIT_BYPASS];
		active_d = fast_mode_ready_o && cutting_i && (code_q == CODE_ON || bypass);
		cut_alt  = accel_sw && cutting_i;
		if (active_d) begin
			vel_mult = regs_q[`IDX_FAST_OVR];
		end else if (gain_sw && cutting_i) begin
			vel_mult = regs_q[`IDX_CUT_OVR];
		end else begin
			vel_mult = `PCT_UNITY;
		end
		cur_gain_d = active_d ? regs_q[`IDX_FAST_MAG] : `PCT_UNITY;
		tc_d  = cut_alt ? regs_q[`IDX_TC_CUT] : regs_q[`IDX_TC_BASE];
		pff_d = cut_alt ? regs_q[`IDX_PFF_CUT] : regs_q[`IDX_PFF_BASE];
		vff_d = cut_alt ? regs_q[`IDX_VFF_CUT] : regs_q[`IDX_VFF_BASE];
		res_d  = regs_q[`IDX_RES_COEF];
		tqf_d  = regs_q[`IDX_MODE_CFG][`BIT_TQ_FILT];
		resf_d = regs_q[`IDX_MODE_CFG][`BIT_RES_FILT];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_mode_active_o    <= 1'b0;
			fast_cycle_o          <= 1'b0;
			current_gain_o        <= `PCT_UNITY;
			fine_accel_decel_o    <= '0;
			pos_feed_forward_o    <= '0;
			vel_feed_forward_o    <= '0;
			resonance_coef_o      <= '0;
			torque_filter_en_o    <= 1'b0;
			resonance_filter_en_o <= 1'b0;
		end else if (tick) begin
			fast_mode_active_o    <= active_d;
			fast_cycle_o          <= active_d;
			current_gain_o        <= cur_gain_d;
			fine_accel_decel_o    <= tc_d;
			pos_feed_forward_o    <= pff_d;
			vel_feed_forward_o    <= vff_d;
			resonance_coef_o      <= res_d;
			torque_filter_en_o    <= tqf_d;
			resonance_filter_en_o <= resf_d;
		end
	end

	servo_param_math i_servo_param_math (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.tick_i           (tick),
		.vel_base_i       (regs_q[`IDX_VEL_BASE]),
		.vel_mult_i       (vel_mult),
		.max_current_i    (regs_q[`IDX_MAX_CUR]),
		.clamp_i          (fast_mode_active_o),
		.torque_command_i (torque_command_i),
		.vel_gain_o       (vel_gain_o),
		.torque_command_o (torque_command_o)
	);

	property p_enter_active;
		@(posedge clk_i) disable iff (rst_i)
		tick && fast_mode_ready_o && code_q == CODE_ON && cutting_i |=> fast_mode_active_o;
	endproperty
	a_enter_active: assert property (p_enter_active) else $error("active flag missing in fast cutting");

	property p_rapid_inactive;
		@(posedge clk_i) disable iff (rst_i)
		tick && !cutting_i |=> !fast_mode_active_o && current_gain_o == `PCT_UNITY;
	endproperty
	a_rapid_inactive: assert property (p_rapid_inactive) else $error("fast mode outside cutting");

	property p_bypass_active;
		@(posedge clk_i) disable iff (rst_i)
		tick && fast_mode_ready_o && bypass && cutting_i |=> fast_mode_active_o;
	endproperty
	a_bypass_active: assert property (p_bypass_active) else $error("bypass did not activate mode");

	property p_ready_gates;
		@(posedge clk_i) disable iff (rst_i)
		!fast_mode_ready_o |-> !fast_mode_active_o;
	endproperty
	a_ready_gates: assert property (p_ready_gates) else $error("active without ready");

	property p_fast_gain;
		@(posedge clk_i) disable iff (rst_i)
		tick && active_d |=> fast_cycle_o && current_gain_o == $past(regs_q[`IDX_FAST_MAG]);
	endproperty
	a_fast_gain: assert property (p_fast_gain) else $error("fast current gain not applied");

	property p_cut_tc;
		@(posedge clk_i) disable iff (rst_i)
		tick && accel_sw && cutting_i |=> fine_accel_decel_o == $past(regs_q[`IDX_TC_CUT]);
	endproperty
	a_cut_tc: assert property (p_cut_tc) else $error("cutting time constant not chosen");

	property p_base_ff;
		@(posedge clk_i) disable iff (rst_i)
		tick && !(accel_sw && cutting_i) |=> pos_feed_forward_o == $past(regs_q[`IDX_PFF_BASE]);
	endproperty
	a_base_ff: assert property (p_base_ff) else $error("base feed-forward not chosen");

	property p_ovr_range;
		@(posedge clk_i) disable iff (rst_i)
		wr_en && idx == `IDX_CUT_OVR && (wr_val < `CUT_OVR_MIN || wr_val > `CUT_OVR_MAX)
			|=> regs_q[`IDX_CUT_OVR] == $past(regs_q[`IDX_CUT_OVR]);
	endproperty
	a_ovr_range: assert property (p_ovr_range) else $error("out-of-range override stored");

	property p_cycle_hold;
		@(posedge clk_i) disable iff (rst_i)
		!$past(tick) |-> $stable(fine_accel_decel_o) && $stable(fast_mode_active_o);
	endproperty
	a_cycle_hold: assert property (p_cycle_hold) else $error("parameter moved between ticks");

	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held longer than one cycle");

	c_fast_cut: cover property (@(posedge clk_i) disable iff (rst_i) tick && active_d);
	c_gain_sw: cover property (@(posedge clk_i) disable iff (rst_i) tick && gain_sw && cutting_i && !active_d);
	c_accel_sw: cover property (@(posedge clk_i) disable iff (rst_i) tick && cut_alt);

endmodule : cutting_rapid_gain_select

// *** sim/interp_model.sv ***
// Purpose: Program interpreter stand-in that drives the feed type and the mode codes.
// Assumes: Codes are one-clock pulses launched just after a rising edge.
// Notes:   The gap argument inserts idle cycles, so codes can come promptly or slowly.
`timescale 1ns/100ps

module interp_model (
	// Clock.
	input  wire logic clk_i,
	// Interpreter outputs.
	output logic      cutting_o,
	output logic      enter_o,
	output logic      leave_o
);
	initial begin
		cutting_o = 1'b0;
		enter_o   = 1'b0;
		leave_o   = 1'b0;
	end

	task automatic feed(input logic cut);
		@(posedge clk_i);
		cutting_o <= cut;
	endtask : feed

	// Codes follow program order; an enter and a leave in one block go out together.
	task automatic code(input logic ent, input logic lve, input int gap);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		enter_o <= ent;
		leave_o <= lve;
		@(posedge clk_i);
		enter_o <= 1'b0;
		leave_o <= 1'b0;
	endtask : code
endmodule : interp_model

// *** sim/cutting_rapid_gain_select_tb_top.sv ***
// Purpose: Self-checking bench for the cutting/rapid gain selector.
// Assumes: A short servo cycle; outputs are sampled after two full servo cycles.
// Notes:   Expected values are queued by the driver and compared by a watcher process.
`timescale 1ns/100ps
`include "gain_select_cfg.svh"

module cutting_rapid_gain_select_tb_top
	import gain_select_pkg::*;
;
	localparam int SV = 16;
	typedef struct {int sel; logic [31:0] exp; string name;} note_t;

	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               cyc_i = 1'b0;
	logic               stb_i = 1'b0;
	logic               we_i = 1'b0;
	logic        [7:0]  adr_i = 8'h00;
	logic        [3:0]  sel_i = 4'h0;
	logic        [31:0] dat_i = 32'h0;
	logic               opt_i = 1'b1;
	logic               cap_i = 1'b1;
	logic signed [15:0] tq_i = 16'sh0000;
	logic               snap_q = 1'b0;
	logic        [31:0] rng = 32'h0e748b8f;
	logic        [31:0] ov [13];
	logic        [31:0] dat_o;
	logic        [24:0] vg_o;
	word_t              cg_o, fad_o, pff_o, vff_o, res_o;
	logic signed [15:0] tq_o;
	logic               ack_o, fc_o, tqf_o, resf_o, rdy_o, act_o, cut, ent, lve;
	note_t              notes[$];
	note_t              cur;
	int                 miscompares = 0;
	int                 tests_run = 0;

	always #25 clk_i = ~clk_i;

	cutting_rapid_gain_select #(.SERVO_CYCLES(SV)) i_cutting_rapid_gain_select (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fast_option_i(opt_i),
		.fast_capable_i(cap_i), .cutting_i(cut), .mode_enter_code_i(ent), .mode_leave_code_i(lve),
		.torque_command_i(tq_i), .torque_command_o(tq_o), .vel_gain_o(vg_o), .current_gain_o(cg_o),
		.fast_cycle_o(fc_o), .fine_accel_decel_o(fad_o), .pos_feed_forward_o(pff_o),
		.vel_feed_forward_o(vff_o), .resonance_coef_o(res_o), .torque_filter_en_o(tqf_o),
		.resonance_filter_en_o(resf_o), .fast_mode_ready_o(rdy_o), .fast_mode_active_o(act_o));

	interp_model i_interp_model (.clk_i(clk_i), .cutting_o(cut), .enter_o(ent), .leave_o(lve));

	always_comb begin
		ov = '{dat_o, {7'h00, vg_o}, {16'h0, cg_o}, {31'h0, fc_o}, {16'h0, fad_o}, {16'h0, pff_o},
			{16'h0, vff_o}, {16'h0, res_o}, {31'h0, tqf_o}, {31'h0, resf_o}, {31'h0, rdy_o},
			{31'h0, act_o}, {16'h0, tq_o}};
	end

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	task automatic test_done();
		if (notes.size() != 0) miscompares++;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	// Read data is judged at the ack edge; level outputs at the edge after a snapshot request.
	always @(posedge clk_i) begin
		if ((ack_o === 1'b1 && we_i === 1'b0) || snap_q) begin
			cur = notes.pop_front();
			check(cur.name, ov[cur.sel], cur.exp);
		end
	end

	task automatic want(input int s, input logic [31:0] e, input string n);
		notes.push_back('{s, e, n});
		@(posedge clk_i);
		snap_q <= 1'b1;
		@(posedge clk_i);
		snap_q <= 1'b0;
	endtask : want

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'h3;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) begin
			miscompares++;
			test_done();
		end
	endtask : wb

	task automatic wr(input logic [3:0] i, input logic [15:0] d);
		wb(1'b1, {2'b00, i, 2'b00}, {16'h0, d});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		notes.push_back('{0, e, n});
		wb(1'b0, a, 32'h0);
	endtask : rd

	task automatic settle();
		repeat (2 * SV + 2) @(posedge clk_i);
	endtask : settle

	// The straps are caught once per reset, so a second reset stands in for a power cycle.
	task automatic do_reset(input logic opt, input logic cap);
		rst_i <= 1'b1;
		opt_i <= opt;
		cap_i <= cap;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
	endtask : do_reset

	initial begin
		logic [15:0] b;
		do_reset(1'b1, 1'b1);
		for (int i = 0; i < 15; i++)
			if (i != 1) rd(8'(4 * i), (i > 2 && i < 6) ? 32'h64 : (i == 14 ? 32'hffff : 32'h0), "reset");
		wr(4'hf, 16'h0005);
		rd(8'h3c, 32'h0, "unmapped");
		rd(8'h42, 32'h0, "misaligned");
		wr(`IDX_DIAG, 16'h0000);
		rd(8'h04, 32'h2, "diag");
		want(10, 32'h1, "ready");
		$display("test registers done");
		wr(`IDX_VEL_BASE, 16'h0080);
		wr(`IDX_CUT_OVR, 16'h00c8);
		i_interp_model.feed(1'b1);
		settle();
		want(1, 32'd150, "gain off");
		wr(`IDX_FEED_SW, 16'h0002);
		settle();
		want(1, 32'd300, "gain cut");
		i_interp_model.feed(1'b0);
		settle();
		want(1, 32'd150, "gain rapid");
		wr(`IDX_CUT_OVR, 16'd49);
		rd(8'h0c, 32'd200, "ovr low");
		wr(`IDX_CUT_OVR, 16'd401);
		rd(8'h0c, 32'd200, "ovr high");
		wr(`IDX_CUT_OVR, 16'd50);
		rd(8'h0c, 32'd50, "ovr min");
		wr(`IDX_CUT_OVR, 16'd400);
		rd(8'h0c, 32'd400, "ovr max");
		i_interp_model.feed(1'b1);
		for (int k = 0; k < 4; k++) begin
			b = 16'(xs());
			wr(`IDX_VEL_BASE, b);
			tq_i <= 16'(xs() % 600);
			settle();
			want(1, ((32'd256 + b) * 32'd400) >> 8, "gain rand");
			want(12, 32'(tq_i), "torque pass");
		end
		$display("test gain done");
		wr(`IDX_TC_BASE, 16'd40);
		wr(`IDX_TC_CUT, 16'd16);
		wr(`IDX_PFF_BASE, 16'h0011);
		wr(`IDX_PFF_CUT, 16'h0022);
		wr(`IDX_VFF_BASE, 16'h0033);
		wr(`IDX_VFF_CUT, 16'h0044);
		wr(`IDX_RES_COEF, 16'h0055);
		for (int k = 1; k < 4; k++) begin
			wr(`IDX_FEED_SW, {14'h0, 1'b1, k[1]});
			i_interp_model.feed(k[0]);
			settle();
			want(4, (k == 3) ? 32'd16 : 32'd40, "time const");
			want(5, (k == 3) ? 32'h22 : 32'h11, "pos ff");
			want(6, (k == 3) ? 32'h44 : 32'h33, "vel ff");
			want(7, 32'h55, "resonance");
		end
		$display("test accel done");
		wr(`IDX_VEL_BASE, 16'h0080);
		wr(`IDX_FAST_OVR, 16'd300);
		wr(`IDX_FAST_MAG, 16'd150);
		wr(`IDX_FAST_MAG, 16'd271);
		rd(8'h14, 32'd150, "mag high");
		wr(`IDX_MAX_CUR, 16'd1000);
		tq_i <= 16'sd2000;
		i_interp_model.feed(1'b0);
		i_interp_model.code(1'b1, 1'b0, 0);
		settle();
		want(11, 32'h0, "rapid in mode");
		i_interp_model.feed(1'b1);
		settle();
		want(11, 32'h1, "active");
		want(3, 32'h1, "fast cycle");
		want(2, 32'd150, "current gain");
		want(1, 32'd450, "fast gain");
		want(12, 32'd700, "torque clamp");
		tq_i <= -16'sd2000;
		want(12, 32'h0000fd44, "torque clamp neg");
		tq_i <= 16'sd2000;
		rd(8'h04, 32'h3, "diag on");
		i_interp_model.code(1'b0, 1'b1, 3);
		settle();
		want(11, 32'h0, "left");
		want(2, 32'd100, "gain unity");
		want(12, 32'd2000, "torque free");
		want(1, 32'd600, "cut gain");
		i_interp_model.code(1'b1, 1'b1, 0);
		settle();
		want(11, 32'h0, "leave wins");
		wr(`IDX_MODE_CFG, 16'h0007);
		settle();
		want(11, 32'h1, "bypass");
		want(8, 32'h1, "torque filter");
		want(9, 32'h1, "res filter");
		$display("test fast mode done");
		do_reset(1'b1, 1'b0);
		wr(`IDX_MODE_CFG, 16'h0001);
		settle();
		want(10, 32'h0, "not ready");
		want(11, 32'h0, "bypass unready");
		do_reset(1'b0, 1'b1);
		want(10, 32'h0, "no option");
		$display("test strap done");
		repeat (4) @(posedge clk_i);
		test_done();
	end
endmodule : cutting_rapid_gain_select_tb_top
